// ---- hw/freq_list_pkg.sv ----
package freq_list_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (one aligned 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_RATE = 5'h04;
  localparam logic [4:0] OFF_LEN = 5'h08;
  localparam logic [4:0] OFF_PTR = 5'h0C;
  localparam logic [4:0] OFF_FREQ = 5'h10;
  localparam logic [4:0] OFF_CMD = 5'h14;
  localparam logic [4:0] OFF_STAT = 5'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_TOUT_LSB = 3;
  localparam int CTRL_EN_BIT = 5;
  localparam int CMD_MANUAL_BIT = 0;
  localparam int CMD_ADV_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_TOUT_BIT = 2;
  localparam int STAT_INIT_BIT = 3;
  localparam int STAT_IDX_LSB = 16;

  // ---------------------------------------------------------------
  // values after reset and fixed figures
  // ---------------------------------------------------------------
  localparam logic [5:0] CTRL_RST = 6'h20;
  localparam logic [15:0] RATE_RST = 16'h000A;
  localparam logic [9:0] LEN_MAX = 10'h200;
  localparam logic [31:0] KHZ_STEP = 32'h000003E8;
  localparam int unsigned CLK_HZ = 10000000;

  // ---------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_MANUAL, SRC_EXTERNAL} trig_src_t;
  typedef enum logic [1:0] {TOUT_OFF, TOUT_RISING, TOUT_FALLING} tout_mode_t;
  typedef enum logic [1:0] {PH_INIT, PH_IDLE, PH_RUN} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [8:0] init_idx;
    logic [5:0] ctrl;
    logic [15:0] rate;
    logic [9:0] len;
    logic [8:0] ptr;
    logic [8:0] idx;
    logic [15:0] cnt;
    logic [25:0] pass_cnt;
    logic [31:0] freq;
    logic trig_out;
    logic sync;
    logic wait_r;
    logic [31:0] rdata;
    logic [2:0] ext_pipe;
  } seq_state_t;

endpackage

// ---- hw/frequency_list_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none

module frequency_list_sequencer
  import freq_list_pkg::*;
#(
  parameter int ENTRIES = 512
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ext_trig_in,
  output logic [31:0] synth_freq,
  output logic trig_out,
  output logic sync_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] khz_value(input logic [8:0] i);
    khz_value = 32'(({23'h0, i} + 32'h1) * KHZ_STEP);
  endfunction

  // zero or oversize length would stall the walk, so fold it to full
  function automatic logic [9:0] eff_len(input logic [9:0] l);
    eff_len = (l == 10'h0 || l > LEN_MAX) ? LEN_MAX : l;
  endfunction

  function automatic logic [15:0] eff_rate(input logic [15:0] r);
    eff_rate = (r == 16'h0) ? 16'h1 : r;
  endfunction

  seq_state_t s, n;
  logic [31:0] table_mem [ENTRIES];
  logic mem_we;
  logic [8:0] mem_wa;
  logic [31:0] mem_wd;
  trig_src_t src;
  tout_mode_t tout;
  logic [15:0] rate_e;
  logic [9:0] len_e;
  logic [25:0] pass_total;
  logic [25:0] half_pass;
  logic ext_edge;
  logic manual_cmd;
  logic start;
  logic bus_ack;
  logic bus_wr;
  logic last_tick;
  logic last_entry;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    mem_we = 1'b0;
    mem_wa = s.ptr;
    mem_wd = writedata;
    src = trig_src_t'(s.ctrl[CTRL_SRC_LSB +: 2]);
    tout = tout_mode_t'(s.ctrl[CTRL_TOUT_LSB +: 2]);
    rate_e = eff_rate(s.rate);
    len_e = eff_len(s.len);
    pass_total = 26'({16'h0, len_e} * {10'h0, rate_e});
    half_pass = 26'((pass_total + 26'h1) >> 1);
    // two flops of synchroniser, third only for edge detection
    n.ext_pipe = {s.ext_pipe[1:0], ext_trig_in};
    ext_edge = s.ctrl[CTRL_EDGE_BIT] ? (s.ext_pipe[2] & ~s.ext_pipe[1]) :
                                       (~s.ext_pipe[2] & s.ext_pipe[1]);
    bus_wr = write & ~s.wait_r;
    manual_cmd = bus_wr && address == OFF_CMD && writedata[CMD_MANUAL_BIT];

    // trigger source decides what launches a pass
    unique case (src)
      SRC_MANUAL: start = manual_cmd;
      SRC_EXTERNAL: start = ext_edge;
      default: start = s.ctrl[CTRL_EN_BIT];
    endcase

    // power-up fill, one entry per clock, bus held off meanwhile
    if (s.phase == PH_INIT) begin
      mem_we = 1'b1;
      mem_wa = s.init_idx;
      mem_wd = khz_value(s.init_idx);
      n.init_idx = 9'(s.init_idx + 9'h1);
      if (s.init_idx == 9'(ENTRIES - 1)) begin
        n.phase = PH_IDLE;
      end
    end

    // list walk; a trigger during a pass is ignored on purpose
    last_tick = s.cnt == 16'(rate_e - 16'h1);
    last_entry = {1'b0, s.idx} == 10'(len_e - 10'h1);
    if (s.phase == PH_IDLE && start) begin
      n.phase = PH_RUN;
      n.idx = 9'h0;
      n.cnt = 16'h0;
      n.pass_cnt = 26'h0;
    end else if (s.phase == PH_RUN) begin
      n.cnt = 16'(s.cnt + 16'h1);
      n.pass_cnt = 26'(s.pass_cnt + 26'h1);
      if (last_tick) begin
        n.cnt = 16'h0;
        if (last_entry) begin
          if (src == SRC_INTERNAL && s.ctrl[CTRL_EN_BIT]) begin
            n.idx = 9'h0;
            n.pass_cnt = 26'h0;
          end else begin
            n.phase = PH_IDLE;
          end
        end else begin
          n.idx = 9'(s.idx + 9'h1);
        end
      end
    end

    // only the frequency word moves; phase accumulator is left alone
    if (n.phase == PH_RUN) begin
      n.freq = table_mem[n.idx];
    end
    n.sync = n.phase == PH_RUN && n.pass_cnt < half_pass;
    unique case (tout)
      TOUT_RISING: n.trig_out = n.phase == PH_RUN;
      TOUT_FALLING: n.trig_out = n.phase != PH_RUN;
      default: n.trig_out = 1'b0;
    endcase
    if (src == SRC_EXTERNAL) begin
      n.trig_out = 1'b0;
    end

    // bus: one wait cycle, then answer; write lands one edge after the ack edge, while waitrequest is low
    bus_ack = (read | write) & s.wait_r & (s.phase != PH_INIT);
    n.wait_r = ~bus_ack;
    if (bus_ack) begin
      unique case (address)
        OFF_CTRL: n.rdata = {26'h0, s.ctrl};
        OFF_RATE: n.rdata = {16'h0, s.rate};
        OFF_LEN: n.rdata = {22'h0, s.len};
        OFF_PTR: n.rdata = {23'h0, s.ptr};
        OFF_FREQ: n.rdata = table_mem[s.ptr];
        OFF_STAT: begin
          n.rdata = 32'h0;
          n.rdata[STAT_RUN_BIT] = s.phase == PH_RUN;
          n.rdata[STAT_SYNC_BIT] = s.sync;
          n.rdata[STAT_TOUT_BIT] = s.trig_out;
          n.rdata[STAT_INIT_BIT] = s.phase == PH_INIT;
          n.rdata[STAT_IDX_LSB +: 9] = s.idx;
        end
        default: n.rdata = 32'h0;
      endcase
    end
    if (bus_wr) begin
      unique case (address)
        OFF_CTRL: n.ctrl = writedata[5:0];
        OFF_RATE: n.rate = writedata[15:0];
        OFF_LEN: n.len = writedata[9:0];
        OFF_PTR: n.ptr = writedata[8:0];
        OFF_FREQ: mem_we = 1'b1;
        OFF_CMD: begin
          if (writedata[CMD_ADV_BIT]) begin
            n.ptr = 9'(s.ptr + 9'h1);
          end
        end
        default: n.ptr = s.ptr;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '{phase: PH_INIT, init_idx: 9'h0, ctrl: CTRL_RST, rate: RATE_RST,
             len: LEN_MAX, ptr: 9'h0, idx: 9'h0, cnt: 16'h0, pass_cnt: 26'h0,
             freq: 32'h0, trig_out: 1'b0, sync: 1'b0, wait_r: 1'b1,
             rdata: 32'h0, ext_pipe: 3'h0};
    end else begin
      s <= n;
    end
  end

  // table storage has no reset; the init phase fills it
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      table_mem[mem_wa] <= mem_wd;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.wait_r;
  assign synth_freq = s.freq;
  assign trig_out = s.trig_out;
  assign sync_out = s.sync;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_entry_hold: assert property (
    s.phase == PH_RUN && s.cnt != 16'(rate_e - 16'h1) |=> $stable(s.freq) && $stable(s.idx))
    else $error("entry changed before its period ended");

  chk_pass_length: assert property (
    s.phase == PH_RUN && last_tick && last_entry |-> s.pass_cnt == 26'(pass_total - 26'h1))
    else $error("pass length differs from len times rate");

  chk_init_table: assert property (
    s.phase == PH_INIT |-> mem_we && mem_wd == 32'(({23'h0, s.init_idx} + 32'h1) * 32'h000003E8))
    else $error("power-up entry not n kHz");

  chk_advance_ptr: assert property (
    bus_wr && address == OFF_CMD && writedata[CMD_ADV_BIT] |=> s.ptr == 9'($past(s.ptr) + 9'h1))
    else $error("advance did not bump pointer");

  chk_internal_wrap: assert property (
    s.phase == PH_RUN && last_tick && last_entry && src == SRC_INTERNAL && s.ctrl[CTRL_EN_BIT]
    |=> s.phase == PH_RUN && s.idx == 9'h0)
    else $error("internal mode did not wrap to first entry");

  chk_manual_start: assert property (
    s.phase == PH_IDLE && src == SRC_MANUAL && manual_cmd |=> s.phase == PH_RUN && s.idx == 9'h0)
    else $error("manual trigger did not start a pass");

  chk_ext_start: assert property (
    s.phase == PH_IDLE && src == SRC_EXTERNAL && ext_edge |=> s.phase == PH_RUN)
    else $error("external edge did not start a pass");

  chk_edge_select: assert property (
    src == SRC_EXTERNAL && s.phase == PH_IDLE && s.ext_pipe[2] != s.ext_pipe[1] && !ext_edge
    |=> s.phase == PH_IDLE)
    else $error("unselected trigger edge started a pass");

  chk_tout_off: assert property (
    tout == TOUT_OFF || src == SRC_EXTERNAL |=> !trig_out)
    else $error("trigger output active while it should be off");

  chk_tout_level: assert property (
    (tout == TOUT_RISING || tout == TOUT_FALLING) && src != SRC_EXTERNAL && $stable(s.ctrl)
    |-> trig_out == ((s.phase == PH_RUN) == (tout == TOUT_RISING)))
    else $error("trigger output does not track the pass");

  chk_sync_rise: assert property (
    s.phase == PH_RUN && s.pass_cnt == 26'h0 |-> sync_out ##1 (sync_out || half_pass == 26'h1))
    else $error("sync not high at first entry");

  // sync drops once half the pass has gone by
  chk_sync_fall: assert property (
    s.phase == PH_RUN && 26'(s.pass_cnt + 26'h1) == half_pass && !(last_tick && last_entry)
    |=> !sync_out)
    else $error("sync did not fall at half pass");

  chk_sync_idle: assert property (
    s.phase != PH_RUN |-> !sync_out)
    else $error("sync high with no accepted pass");

  chk_freq_idle: assert property (
    s.phase == PH_IDLE && !start |=> $stable(synth_freq))
    else $error("frequency word moved while idle");

  chk_entry_step: assert property (
    s.phase == PH_RUN && last_tick && !last_entry
    |=> s.phase == PH_RUN && s.idx == 9'($past(s.idx) + 9'h1))
    else $error("entry did not advance after its period");

  chk_manual_only: assert property (
    src == SRC_MANUAL && s.phase == PH_IDLE && !manual_cmd |=> s.phase == PH_IDLE)
    else $error("manual mode started without a command");

  chk_pass_end: assert property (
    s.phase == PH_RUN && last_tick && last_entry && !(src == SRC_INTERNAL && s.ctrl[CTRL_EN_BIT])
    |=> s.phase == PH_IDLE)
    else $error("one-shot pass did not stop at its end");

  // the bus stays held off until every entry has its power-up value
  chk_fill_hold: assert property (
    s.phase == PH_INIT |-> waitrequest)
    else $error("bus answered during table fill");

  chk_bus_answer: assert property (
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule

`default_nettype wire

// ---- dv/trig_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module trig_src_model #(
  parameter int HOLD = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic fire,
  input wire logic fall,
  output logic ext_trig
);
  int cnt;
  logic pulse;

  // four-cycle pulse, then a quiet spell so the period outlasts one pass
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      pulse <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      pulse <= (cnt > HOLD);
    end else if (fire) begin
      cnt <= HOLD + 3;
      pulse <= 1'b1;
    end
  end

  // idle level follows the chosen edge so a pulse gives exactly one such edge
  assign ext_trig = fall ^ pulse;
endmodule
`default_nettype wire

// ---- dv/test_frequency_list_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_frequency_list_sequencer;
  import freq_list_pkg::*;
  localparam logic [31:0] VA = 32'h00011111;
  localparam logic [31:0] VB = 32'h00022222;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic fire = 1'b0;
  logic fall = 1'b0;
  logic [31:0] readdata, synth_freq, rd;
  logic waitrequest, trig_out, sync_out, ext_trig_in;
  int bad_count = 0;
  int n_checks = 0;
  int idx[4] = '{0, 1, 255, 511};

  always #50 sys_clk = ~sys_clk;

  frequency_list_sequencer uut (.sys_clk(sys_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ext_trig_in(ext_trig_in), .synth_freq(synth_freq),
    .trig_out(trig_out), .sync_out(sync_out));

  trig_src_model src (.sys_clk(sys_clk), .reset(reset), .fire(fire), .fall(fall),
    .ext_trig(ext_trig_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 2000) begin
        bad_count++;
        summarize();
      end
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  task automatic wait_sync(input logic v);
    int n;
    n = 0;
    while (sync_out !== v) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 20) begin
        bad_count++;
        summarize();
      end
    end
  endtask

  task automatic pulse_src;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask

  // list of two entries, three cycles each: twelve cycles from the pass start
  task automatic pass_chk(input logic [1:0] tm, input bit rep);
    int k;
    logic run;
    #1;
    wait_sync(1'b1);
    for (int i = 0; i < 12; i++) begin
      k = rep ? i % 6 : i;
      run = rep || i < 6;
      check(synth_freq, (k < 3) ? VA : VB);
      check({31'h0, sync_out}, {31'h0, k < 3});
      check({31'h0, trig_out}, {31'h0, tm == 2'd1 ? run : (tm == 2'd2 && !run)});
      @(posedge sys_clk);
      #1;
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    rdchk(OFF_CTRL, {26'h0, CTRL_RST});
    rdchk(OFF_RATE, {16'h0, RATE_RST});
    rdchk(OFF_LEN, {22'h0, LEN_MAX});
    rdchk(5'h1C, 32'h00000000);
    rdchk(OFF_CMD, 32'h00000000);
    foreach (idx[j]) begin
      bus(1'b1, OFF_PTR, 32'(idx[j]));
      rdchk(OFF_FREQ, KHZ_STEP * 32'(idx[j] + 1));
    end
    // manual mode first, then let the power-up pass run out
    bus(1'b1, OFF_CTRL, 32'h00000009);
    for (int n = 0; n <= 6000; n++) begin
      bus(1'b0, OFF_STAT, 32'h00000000);
      if (rd[STAT_RUN_BIT] === 1'b0) break;
      if (n == 6000) begin
        bad_count++;
        summarize();
      end
    end
    bus(1'b1, OFF_LEN, 32'h00000002);
    bus(1'b1, OFF_RATE, 32'h00000003);
    bus(1'b1, OFF_PTR, 32'h000001FF);
    bus(1'b1, OFF_CMD, 32'h00000002);
    rdchk(OFF_PTR, 32'h00000000);
    bus(1'b1, OFF_FREQ, VA);
    bus(1'b1, OFF_CMD, 32'h00000002);
    bus(1'b1, OFF_FREQ, VB);
    rdchk(OFF_PTR, 32'h00000001);
    rdchk(OFF_FREQ, VB);
    // each trigger-output mode under manual launch
    for (int tm = 0; tm < 3; tm++) begin
      bus(1'b1, OFF_CTRL, 32'h00000001 | 32'(tm << 3));
      @(posedge sys_clk);
      #1;
      check({31'h0, trig_out}, {31'h0, tm == 2});
      bus(1'b1, OFF_CMD, 32'h00000001);
      pass_chk(2'(tm), 1'b0);
    end
    // edges are not triggers outside external mode
    pulse_src();
    repeat (4) @(posedge sys_clk);
    rdchk(OFF_STAT, 32'h00010004);
    // external rising; manual command ignored, trigger output silent
    bus(1'b1, OFF_CTRL, 32'h0000000A);
    bus(1'b1, OFF_CMD, 32'h00000001);
    repeat (10) @(posedge sys_clk);
    rdchk(OFF_STAT, 32'h00010000);
    pulse_src();
    pass_chk(2'd0, 1'b0);
    // move the idle level while in manual so no stray edge counts
    bus(1'b1, OFF_CTRL, 32'h00000001);
    fall <= 1'b1;
    repeat (30) @(posedge sys_clk);
    bus(1'b1, OFF_CTRL, 32'h00000006);
    pulse_src();
    pass_chk(2'd0, 1'b0);
    // internal source repeats with no gap
    bus(1'b1, OFF_CTRL, 32'h00000028);
    pass_chk(2'd1, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
